/* File: inc/rlpc_regs.svh */
// register layout and constants for the lane power control register
`ifndef RLPC_REGS_SVH
`define RLPC_REGS_SVH
`define RLPC_REG_ADDR 8'h09
`define RLPC_BIT_LANE_SWAP 7
`define RLPC_BIT_POLARITY 6
`define RLPC_BIT_RSVD 5
`define RLPC_BIT_ACT_DET 4
`define RLPC_BIT_PWR_DOWN 3
`define RLPC_BIT_HPD_AUTO 2
`define RLPC_RATE_LSB 0
`define RLPC_RATE_RESET 2'h2
`define RLPC_RATE_5K 2'h0
`define RLPC_RATE_10K 2'h1
`define RLPC_RATE_100K 2'h2
`define RLPC_RATE_400K 2'h3
`define RLPC_PIN_STRAP_MODE 1'h0
`endif

/* File: inc/rlpc_pkg.sv */
// types shared by the lane power control block
package rlpc_pkg;
  typedef enum logic [1:0] {
    RLPC_RATE_5K,
    RLPC_RATE_10K,
    RLPC_RATE_100K,
    RLPC_RATE_400K
  } rlpc_rate_t;

  typedef struct packed {
    logic polarity_swap;
    logic activity_detect_enable;
    logic forced_power_down;
    logic [1:0] serial_bus_rate_select;
  } rlpc_ctrl_t;

  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rlpc_req_t;
endpackage : rlpc_pkg

/* File: verilog/rlpc_sync.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module rlpc_sync (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic pin_in,
  output logic level_out
);
  logic s1;
  logic s2;
  logic s3;
  logic lvl;
  logic next_lvl;

  // the first stage feeds only the second
  always_comb begin
    next_lvl = lvl;
    if (s2 == s3) begin
      next_lvl = s2;
    end
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      s1 <= 1'h0;
      s2 <= 1'h0;
      s3 <= 1'h0;
      lvl <= 1'h0;
    end else begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
      lvl <= next_lvl;
    end
  end

  assign level_out = lvl;
endmodule : rlpc_sync
`default_nettype wire

/* File: verilog/rlpc_lane_power_ctrl.sv */
// lane power control register with strap loading and lane controls
//
// Operation
// [RULE_01] polarity swap at 1 inverts data and clock lanes, retimer mode only
// [RULE_02] polarity swap at 0, its default, passes lanes unchanged
// [RULE_03] polarity loads from strap pin; host writes dropped in pin-strap mode
// [RULE_04] detect enable at 0 keeps detector off, receiver always normal
// [RULE_05] detect enable at 1 puts receiver in standby when no valid data
// [RULE_06] detect enable loads from strap pin; host writes dropped in pin-strap mode
// [RULE_07] power-down at 1 forces lowest power state; 0 means normal
// [RULE_08] rate field: 00 5k, 01 10k, 10 100k default, 11 400k
// [RULE_09] reserved bit reads zero, writes ignored
`timescale 1ns/10ps
`default_nettype none
`include "rlpc_regs.svh"
module rlpc_lane_power_ctrl #(
  parameter int LANES = 4
) (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire rlpc_pkg::rlpc_req_t req_in,
  output logic [7:0] rdata_out,
  output logic rvalid_out,
  input wire logic if_select_strap_in,
  input wire logic polarity_strap_in,
  input wire logic activity_detect_strap_in,
  input wire logic retimer_mode_in,
  input wire logic clock_activity_in,
  input wire logic [LANES-1:0] lane_in,
  output logic [LANES-1:0] lane_out,
  output logic receiver_standby_out,
  output logic power_down_out,
  output rlpc_pkg::rlpc_ctrl_t ctrl_out
);
  import rlpc_pkg::*;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic if_sel;
  logic pol_pin;
  logic act_pin;
  logic activity;

  rlpc_sync u_sync_sel (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .pin_in(if_select_strap_in),
    .level_out(if_sel)
  );
  rlpc_sync u_sync_pol (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .pin_in(polarity_strap_in),
    .level_out(pol_pin)
  );
  rlpc_sync u_sync_act (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .pin_in(activity_detect_strap_in),
    .level_out(act_pin)
  );
  rlpc_sync u_sync_clk (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .pin_in(clock_activity_in),
    .level_out(activity)
  );

  // ----------------------------------------
  // register state
  // ----------------------------------------
  rlpc_ctrl_t ctrl;
  rlpc_ctrl_t next_ctrl;
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  logic rvalid;
  logic next_rvalid;
  logic hit;
  logic pin_mode;

  assign hit = (req_in.addr == `RLPC_REG_ADDR);
  assign pin_mode = (if_sel == `RLPC_PIN_STRAP_MODE);

  always_comb begin
    next_ctrl = ctrl;
    next_rdata = rdata;
    next_rvalid = 1'h0;
    // in pin-strap mode the straps own these fields continuously
    if (pin_mode) begin
      next_ctrl.polarity_swap = pol_pin; // see [RULE_03]
      next_ctrl.activity_detect_enable = act_pin; // see [RULE_06]
    end
    if (req_in.wr_en && hit) begin
      if (!pin_mode) begin
        next_ctrl.polarity_swap = req_in.wdata[`RLPC_BIT_POLARITY]; // see [RULE_03]
        next_ctrl.activity_detect_enable = req_in.wdata[`RLPC_BIT_ACT_DET]; // see [RULE_06]
      end
      next_ctrl.forced_power_down = req_in.wdata[`RLPC_BIT_PWR_DOWN]; // see [RULE_07]
      next_ctrl.serial_bus_rate_select = req_in.wdata[`RLPC_RATE_LSB +: 2]; // see [RULE_08]
    end
    if (req_in.rd_en) begin
      // a read straight after an answered read gets no answer, so two answers never merge
      next_rvalid = !rvalid;
      next_rdata = 8'h00;
      // unmapped addresses and the reserved bit both read zero
      if (hit) begin
        next_rdata[`RLPC_BIT_POLARITY] = ctrl.polarity_swap;
        next_rdata[`RLPC_BIT_RSVD] = 1'h0; // see [RULE_09]
        next_rdata[`RLPC_BIT_ACT_DET] = ctrl.activity_detect_enable;
        next_rdata[`RLPC_BIT_PWR_DOWN] = ctrl.forced_power_down;
        next_rdata[`RLPC_RATE_LSB +: 2] = ctrl.serial_bus_rate_select;
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      ctrl.polarity_swap <= 1'h0; // see [RULE_02]
      ctrl.activity_detect_enable <= 1'h0; // see [RULE_04]
      ctrl.forced_power_down <= 1'h0;
      ctrl.serial_bus_rate_select <= `RLPC_RATE_RESET; // see [RULE_08]
      rdata <= 8'h00;
      rvalid <= 1'h0;
    end else begin
      ctrl <= next_ctrl;
      rdata <= next_rdata;
      rvalid <= next_rvalid;
    end
  end

  // ----------------------------------------
  // lane and power controls
  // ----------------------------------------
  logic [LANES-1:0] lanes;
  logic [LANES-1:0] next_lanes;
  logic standby;
  logic next_standby;
  logic pd;
  logic next_pd;

  always_comb begin
    next_lanes = lane_in; // see [RULE_02]
    // redriver mode never inverts, the swap only exists on the retimed path
    if (ctrl.polarity_swap && retimer_mode_in) begin
      next_lanes = ~lane_in; // see [RULE_01]
    end
    next_standby = ctrl.activity_detect_enable && !activity; // see [RULE_04] see [RULE_05]
    next_pd = ctrl.forced_power_down; // see [RULE_07]
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      lanes <= '0;
      standby <= 1'h0;
      pd <= 1'h0;
    end else begin
      lanes <= next_lanes;
      standby <= next_standby;
      pd <= next_pd;
    end
  end

  assign lane_out = lanes;
  assign receiver_standby_out = standby;
  assign power_down_out = pd;
  assign ctrl_out = ctrl;
  assign rdata_out = rdata;
  assign rvalid_out = rvalid;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);

  AST_POL_INVERT: assert property ((ctrl.polarity_swap && retimer_mode_in) |=> // see [RULE_01]
    (lane_out == ~$past(lane_in))) else $error("lanes not inverted");
  AST_POL_PASS: assert property (!(ctrl.polarity_swap && retimer_mode_in) |=> // see [RULE_02]
    (lane_out == $past(lane_in))) else $error("lanes altered");
  AST_POL_STRAP: assert property (pin_mode |=> // see [RULE_03]
    (ctrl.polarity_swap == $past(pol_pin))) else $error("polarity not from strap");
  AST_DET_OFF: assert property (!ctrl.activity_detect_enable |=> // see [RULE_04]
    !receiver_standby_out) else $error("standby while detector off");
  AST_DET_ON: assert property ((ctrl.activity_detect_enable && !activity) |=> // see [RULE_05]
    receiver_standby_out) else $error("no standby on idle clock");
  AST_DET_STRAP: assert property (pin_mode |=> // see [RULE_06]
    (ctrl.activity_detect_enable == $past(act_pin))) else $error("detect not from strap");
  AST_PD: assert property ((req_in.wr_en && hit) |=> ##1 // see [RULE_07]
    (power_down_out == $past(req_in.wdata[`RLPC_BIT_PWR_DOWN], 2)))
    else $error("power down not applied");
  AST_RATE: assert property ((req_in.wr_en && hit) |=> // see [RULE_08]
    (ctrl.serial_bus_rate_select == $past(req_in.wdata[`RLPC_RATE_LSB +: 2])))
    else $error("rate not stored");
  AST_RSVD: assert property (rvalid_out |-> !rdata_out[`RLPC_BIT_RSVD]) // see [RULE_09]
    else $error("reserved bit read as one");

  COV_STANDBY: cover property (receiver_standby_out);
  COV_INVERT: cover property (ctrl.polarity_swap && retimer_mode_in);
  COV_PD: cover property (power_down_out);
  COV_RATE400: cover property (ctrl.serial_bus_rate_select == `RLPC_RATE_400K);
endmodule : rlpc_lane_power_ctrl
`default_nettype wire

/* File: dv/rlpc_host_model.sv */
// serial bus host model issuing register requests
`timescale 1ns/10ps
`default_nettype none
module rlpc_host_model (
  input wire logic ref_clk_in,
  output rlpc_pkg::rlpc_req_t req_out
);
  import rlpc_pkg::*;
  initial req_out = '0;
  // released address and data lines show inverted values so stale data never looks valid
  task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data);
    @(posedge ref_clk_in);
    #1;
    req_out = '{wr_en: wr, rd_en: !wr, addr: addr, wdata: data};
    @(posedge ref_clk_in);
    #1;
    req_out = '{wr_en: 1'b0, rd_en: 1'b0, addr: ~addr, wdata: ~data};
    // idle cycle after a read keeps answers apart
    if (!wr) begin
      @(posedge ref_clk_in);
      #1;
    end
  endtask : access
endmodule : rlpc_host_model
`default_nettype wire

/* File: dv/test_retimer_lane_power_ctrl.sv */
// self-checking bench for the lane power control register
`timescale 1ns/10ps
`default_nettype none
`include "rlpc_regs.svh"
module test_retimer_lane_power_ctrl;
  import rlpc_pkg::*;
  logic ref_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic if_sel = 1'b0, pol_strap = 1'b0, det_strap = 1'b0, ret = 1'b0, act = 1'b1;
  logic [3:0] lane = 4'h0;
  logic [3:0] lane_q;
  logic [7:0] rdata, v;
  logic rvalid, stby, pdown;
  rlpc_req_t req;
  rlpc_ctrl_t ctrl;
  logic [7:0] exp_q[$];
  int fails = 0;
  int cmp_count = 0;
  int seed;
  always #50 ref_clk_in = ~ref_clk_in;
  rlpc_host_model u_host (.ref_clk_in(ref_clk_in), .req_out(req));
  rlpc_lane_power_ctrl #(.LANES(4)) u_dut (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
    .req_in(req), .rdata_out(rdata), .rvalid_out(rvalid), .if_select_strap_in(if_sel),
    .polarity_strap_in(pol_strap), .activity_detect_strap_in(det_strap),
    .retimer_mode_in(ret), .clock_activity_in(act), .lane_in(lane), .lane_out(lane_q),
    .receiver_standby_out(stby), .power_down_out(pdown), .ctrl_out(ctrl));
  // ----
  // checking
  // ----
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
    exp_q.push_back(exp);
    u_host.access(1'b0, addr, 8'h00);
  endtask : rd
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask : wait_cyc
  always @(negedge ref_clk_in) begin
    if (rvalid === 1'b1) begin
      if (exp_q.size() == 0) check(rdata, 8'hxx);
      else check(rdata, exp_q.pop_front());
    end
  end
  task automatic final_report;
    if (exp_q.size() != 0) fails++;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report
  initial begin
    #3000000;
    fails++;
    final_report();
  end
  // ----
  // stimulus
  // ----
  initial begin
    seed = $urandom(82722);
    wait_cyc(20);
    reset_in = 1'b0;
    check({3'h0, ctrl}, 8'h02);
    wait_cyc(8);
    rd(`RLPC_REG_ADDR, 8'h02);
    rd(8'h33, 8'h00);
    // pin-strap mode: host writes must not move the strapped fields
    pol_strap = 1'b1;
    det_strap = 1'b1;
    act = 1'b0;
    wait_cyc(8);
    check({7'h0, stby}, 8'h01);
    rd(`RLPC_REG_ADDR, 8'h52);
    u_host.access(1'b1, `RLPC_REG_ADDR, 8'h00);
    rd(`RLPC_REG_ADDR, 8'h50);
    if_sel = 1'b1;
    wait_cyc(8);
    for (int i = 0; i < 12; i++) begin
      v = {6'($urandom_range(63, 0)), i[1:0]};
      {pol_strap, det_strap, ret, act} = 4'($urandom_range(15, 0));
      lane = 4'($urandom_range(15, 0));
      u_host.access(1'b1, `RLPC_REG_ADDR, v);
      wait_cyc(8);
      check({3'h0, ctrl}, {3'h0, v[6], v[4], v[3], v[1:0]});
      check({7'h0, pdown}, {7'h0, v[3]});
      check({4'h0, lane_q}, {4'h0, lane ^ {4{v[6] & ret}}});
      check({7'h0, stby}, {7'h0, v[4] & !act});
      rd(`RLPC_REG_ADDR, v & 8'h5b);
    end
    wait_cyc(4);
    final_report();
  end
endmodule : test_retimer_lane_power_ctrl
`default_nettype wire
